// [logic/bus_hold_pkg.sv]
package bus_hold_pkg;

   localparam int unsigned ADDR_W = 24;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned WAIT_W = 3;

   // reset value of the software wait-state count
   localparam logic [2:0] WAIT_RESET = 3'h7;
   // cycles allowed from reset release to grant while request held
   localparam int unsigned RESET_GRANT_CYCLES = 9;
   localparam logic [3:0] RESET_GRANT_MAX = 4'h9;

   typedef enum {
      ST_RUN,
      ST_ACCESS,
      ST_HOLD
   } hold_state_t;

   // bus cycle request from the core side
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

   // external bus pins as driven by the device
   typedef struct packed {
      logic              oe;
      logic              strobe_n;
      logic              rw;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bus_pins_t;

   typedef struct packed {
      logic              req_meta;
      logic              req_sync_n;
      logic              req_prev_n;
      hold_state_t       state;
      logic [WAIT_W-1:0] wait_cnt;
      logic              pend_valid;
      bus_req_t          pend;
      bus_req_t          cur;
      logic              grant_n;
      logic              release_wait;
      logic              stall;
      logic              done;
      bus_pins_t         pins;
   } hold_regs_t;

endpackage

// [logic/bus_hold_ctrl.sv]
// Operation
// [R1] request is double-synchronised; a missed setup costs one more cycle
// [R2] hold_disable overrides the bus request
// [R3] setting hold_disable leaves hold and blocks new holds
// [R4] no primary bus access while the request is honoured
// [R5] core keeps running in hold; stalls only on a bus access
// [R6] one write may pend during hold; a second write stalls
// [R7] request sampled once per cycle, checked before the bus cycle ends
// [R8] master holds request at least wait_state_count plus 3 cycles
// [R9] master keeps request until grant has been low one cycle
// [R10] grant low on request; released one cycle after request rises
// [R11] request honoured from reset; grant within nine cycles
// [R12] reset loads wait_state_count with seven
// [R13] bus outputs released while the grant is asserted
`timescale 1ns/1ps
`default_nettype none
module bus_hold_ctrl (
   input  wire logic                  ref_clk_in,
   input  wire logic                  rstn_in,
   input  wire logic                  bus_req_n_in,
   input  wire logic                  hold_disable_in,
   input  wire logic                  wait_load_in,
   input  wire logic [2:0]            wait_value_in,
   input  wire bus_hold_pkg::bus_req_t core_req_in,
   output logic                       core_stall_out,
   output logic                       core_done_out,
   output logic                       bus_grant_n_out,
   output logic [2:0]                 wait_state_count_out,
   output bus_hold_pkg::bus_pins_t    bus_pins_out
);

   bus_hold_pkg::hold_regs_t r_r;
   bus_hold_pkg::hold_regs_t r_nxt;
   logic                     req_on;
   logic                     accept;

   always_comb begin
      r_nxt = r_r;
      r_nxt.done = 1'b0;
      // [R1] two-stage synchroniser
      r_nxt.req_meta   = bus_req_n_in;
      r_nxt.req_sync_n = r_r.req_meta;
      r_nxt.req_prev_n = r_r.req_sync_n;
      // [R2] disable overrides request
      req_on = !r_r.req_sync_n && !hold_disable_in;
      if (wait_load_in) begin
         r_nxt.wait_cnt = wait_value_in;
      end
      accept = 1'b0;
      case (r_r.state)
         bus_hold_pkg::ST_RUN: begin
            // [R4] request blocks new accesses
            if (req_on) begin
               r_nxt.state   = bus_hold_pkg::ST_HOLD;
               r_nxt.grant_n = 1'b0;
            end else if (r_r.pend_valid) begin
               r_nxt.cur        = r_r.pend;
               r_nxt.pend_valid = 1'b0;
               r_nxt.state      = bus_hold_pkg::ST_ACCESS;
            // a request answered last cycle is still up for one edge; do not take it twice
            end else if (core_req_in.valid && !r_r.done) begin
               accept      = 1'b1;
               r_nxt.cur   = core_req_in;
               r_nxt.state = bus_hold_pkg::ST_ACCESS;
            end
         end
         bus_hold_pkg::ST_ACCESS: begin
            // [R7] request seen before the cycle ends takes effect after it
            r_nxt.state = bus_hold_pkg::ST_RUN;
            if (!r_r.cur.write) begin
               r_nxt.done = !r_r.pend_valid;
            end
         end
         bus_hold_pkg::ST_HOLD: begin
            // [R3] disable ends hold at once
            if (hold_disable_in) begin
               r_nxt.state   = bus_hold_pkg::ST_RUN;
               r_nxt.grant_n = 1'b1;
               r_nxt.release_wait = 1'b0;
            // [R10] release one cycle after request rises
            end else if (r_r.req_sync_n) begin
               if (r_r.release_wait) begin
                  r_nxt.state        = bus_hold_pkg::ST_RUN;
                  r_nxt.grant_n      = 1'b1;
                  r_nxt.release_wait = 1'b0;
               end else begin
                  r_nxt.release_wait = 1'b1;
               end
            end else begin
               r_nxt.release_wait = 1'b0;
            end
            // [R6] first write pends, core continues
            if (core_req_in.valid && core_req_in.write && !r_r.pend_valid) begin
               accept           = 1'b1;
               r_nxt.pend       = core_req_in;
               r_nxt.pend_valid = 1'b1;
            end
         end
         default: begin
            r_nxt.state = bus_hold_pkg::ST_RUN;
         end
      endcase
      if (accept && core_req_in.write) begin
         r_nxt.done = 1'b1;
      end
      // [R5] stall only when a bus access cannot be taken
      r_nxt.stall = core_req_in.valid && !accept && !r_nxt.done && !r_r.done;
      // [R13] pins released while granted
      r_nxt.pins.oe       = (r_nxt.state == bus_hold_pkg::ST_ACCESS);
      r_nxt.pins.strobe_n = !(r_nxt.state == bus_hold_pkg::ST_ACCESS);
      r_nxt.pins.rw       = !r_nxt.cur.write;
      r_nxt.pins.addr     = r_nxt.cur.addr;
      r_nxt.pins.data     = r_nxt.cur.wdata;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         r_r <= '0;
         r_r.req_meta   <= 1'b1;
         r_r.req_sync_n <= 1'b1;
         r_r.req_prev_n <= 1'b1;
         r_r.state      <= bus_hold_pkg::ST_RUN;
         // [R12] seven wait states at reset
         r_r.wait_cnt   <= bus_hold_pkg::WAIT_RESET;
         r_r.grant_n    <= 1'b1;
         r_r.pins.strobe_n <= 1'b1;
         r_r.pins.rw    <= 1'b1;
      end else begin
         // [R11] synchroniser is held in reset; a request held through reset is granted on the third edge after release
         r_r <= r_nxt;
      end
   end

   assign core_stall_out       = r_r.stall;
   assign core_done_out        = r_r.done;
   assign bus_grant_n_out      = r_r.grant_n;
   assign wait_state_count_out = r_r.wait_cnt;
   assign bus_pins_out         = r_r.pins;

endmodule
`default_nettype wire

// [tb/bus_hold_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module bus_hold_asserts (
   input wire logic                    ref_clk_in,
   input wire logic                    rstn_in,
   input wire logic                    bus_req_n_in,
   input wire logic                    hold_disable_in,
   input wire logic                    bus_grant_n_out,
   input wire logic [2:0]              wait_state_count_out,
   input wire bus_hold_pkg::bus_pins_t bus_pins_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence req_on;
      !bus_req_n_in && !hold_disable_in;
   endsequence
   sequence rel_seen;
      $rose(bus_req_n_in) && !bus_grant_n_out && !hold_disable_in;
   endsequence
   grant_on_a: assert property (req_on [*8] |-> ##1 !bus_grant_n_out)
      else $error("grant late");
   grant_sync_a: assert property ($fell(bus_req_n_in) && bus_grant_n_out |=> bus_grant_n_out)
      else $error("grant too early");
   grant_cause_a: assert property ($fell(bus_grant_n_out) |-> !$past(bus_req_n_in))
      else $error("grant without request");
   hold_keep_a: assert property (req_on ##0 !bus_grant_n_out |=> !bus_grant_n_out)
      else $error("grant dropped");
   grant_rel_a: assert property (rel_seen |=> !bus_grant_n_out ##[1:4] bus_grant_n_out)
      else $error("grant release timing");
   hold_disable_a: assert property (hold_disable_in [*2] |-> bus_grant_n_out)
      else $error("grant while disabled");
   no_access_a: assert property (!bus_grant_n_out |-> !bus_pins_out.oe)
      else $error("bus driven in hold");
   wait_rst_a: assert property ($rose(rstn_in) |-> wait_state_count_out == 3'h7)
      else $error("wait count reset");
endmodule
bind bus_hold_ctrl bus_hold_asserts bus_hold_asserts_inst (.*);
`default_nettype wire

// [tb/bus_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input  wire logic       clk_in,
   input  wire logic       start_in,
   input  wire logic [7:0] len_in,
   input  wire logic [2:0] wait_in,
   input  wire logic       grant_n_in,
   output logic            req_n_out
);
   int n;
   int g;
   initial begin
      req_n_out = 1'b1;
      forever begin
         @(posedge clk_in);
         if (start_in) begin
            req_n_out <= 1'b0;
            n = 0;
            g = 0;
            while (n < len_in || n < wait_in + 3 || g < 2) begin
               @(posedge clk_in);
               n++;
               if (grant_n_in === 1'b0) g++;
            end
            req_n_out <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                    clk = 0, rstn = 0, hdis = 0, wl = 1, go = 0;
   logic                    req_n, stall, done, gnt_n;
   logic [2:0]              wc;
   logic [7:0]              len = 8'h0a;
   bus_hold_pkg::bus_req_t  cr = '0;
   bus_hold_pkg::bus_pins_t pins;
   int                      error_cnt = 0, num_checks = 0;
   bus_master_model bus_master_model_inst (.clk_in(clk), .start_in(go), .len_in(len),
      .wait_in(wc), .grant_n_in(gnt_n), .req_n_out(req_n));
   bus_hold_ctrl bus_hold_ctrl_inst (.ref_clk_in(clk), .rstn_in(rstn), .bus_req_n_in(req_n),
      .hold_disable_in(hdis), .wait_load_in(wl), .wait_value_in(3'h2), .core_req_in(cr),
      .core_stall_out(stall), .core_done_out(done), .bus_grant_n_out(gnt_n),
      .wait_state_count_out(wc), .bus_pins_out(pins));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // selects the watched output: 0 grant, 1 done
   function automatic logic pick(input int sel);
      return (sel == 0) ? gnt_n : done;
   endfunction
   // sampled on the falling edge so outputs have settled
   task automatic wait_for(input int sel, input logic v);
      @(negedge clk);
      for (int i = 0; i < 30 && pick(sel) !== v; i++) @(negedge clk);
      if (pick(sel) !== v) begin
         error_cnt++;
         $display("[FAIL] %0t wait timed out", $time);
      end
   endtask
   task hold_go(input logic [7:0] n);
      @(posedge clk) len <= n;
      go <= 1;
      @(posedge clk) go <= 0;
   endtask
   task t_read;
      hold_go(8'h0a);
      wait_for(0, 1'b0);
      chk({gnt_n, pins.oe}, 2'h0);
      @(posedge clk) cr <= {2'h2, 56'h10};
      repeat (3) @(negedge clk);
      chk({stall, done}, 2'h2);
      wait_for(1, 1'b1);
      chk(gnt_n, 1);
      @(posedge clk) cr <= '0;
   endtask
   task t_write;
      hold_go(8'h10);
      wait_for(0, 1'b0);
      @(posedge clk) cr <= {2'h3, 56'ha5};
      wait_for(1, 1'b1);
      chk({done, pins.oe, gnt_n}, 3'h4);
      @(posedge clk) cr <= {2'h3, 56'h5a};
      repeat (2) @(negedge clk);
      chk(stall, 1);
      // pending write goes out first once the grant is released
      wait_for(0, 1'b1);
      @(negedge clk);
      chk({pins.oe, pins.strobe_n, pins.rw}, 3'h4);
      chk(pins.data, 32'ha5);
      wait_for(1, 1'b1);
      chk(gnt_n, 1);
      @(posedge clk) cr <= '0;
   endtask
   task t_hold_disable;
      @(posedge clk) hdis <= 1;
      hold_go(8'h0a);
      repeat (8) @(negedge clk);
      chk(gnt_n, 1);
      @(posedge clk) hdis <= 0;
      wait_for(0, 1'b0);
      @(posedge clk) hdis <= 1;
      repeat (3) @(negedge clk);
      chk(gnt_n, 1);
      @(posedge clk) hdis <= 0;
      repeat (20) @(posedge clk);
   endtask
   task t_reset_req;
      @(posedge clk) rstn <= 0;
      hold_go(8'h0a);
      @(posedge clk) rstn <= 1;
      @(negedge clk);
      chk(wc, 3'h7);
      repeat (9) @(negedge clk);
      chk(gnt_n, 0);
   endtask
   initial forever #10 clk = ~clk;
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1;
      @(posedge clk) wl <= 0;
      @(negedge clk);
      chk(wc, 3'h2);
      t_read;
      t_write;
      t_hold_disable;
      t_reset_req;
      wrap_up;
   end
   // about ten times the expected run
   initial begin
      #20000;
      error_cnt++;
      wrap_up;
   end
endmodule
`default_nettype wire
